// ---- hw/uart_irq_map.svh ----
// bit positions, reset values and level codes of the irq logic
`ifndef UART_IRQ_MAP_SVH
`define UART_IRQ_MAP_SVH

// interrupt mask bit positions
`define MASK_RX 0
`define MASK_TX 1
`define MASK_LS 2
`define MASK_MS 3
`define MASK_SLEEP 4
`define MASK_XOFF 5
`define MASK_RTS 6
`define MASK_CTS 7
`define MASK_RESET 8'h00
`define MASK_LO_KEEP 8'h0F

// line status bit positions
`define LSR_DATA 0
`define LSR_ERR_LSB 1
`define LSR_ERR_MSB 4
`define LSR_TX_EMPTY 5
`define LSR_ALL_EMPTY 6
`define LSR_FIFO_ERR 7
`define LSR_RESET 8'h60

// priority level codes reported with the ready sources
`define LVL_NONE 3'h0
`define LVL_RX 3'h2
`define LVL_TX 3'h3

`endif

// ---- hw/uart_irq_pkg.sv ----
// types shared by the interrupt enable logic
package uart_irq_pkg;

  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_FIFO_INT,
    MODE_FIFO_POLL
  } mode_e;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] rdata;
    logic [7:0] line_status_reg;
    logic rx_rdy;
    logic tx_rdy;
    logic rx_stat;
    logic [2:0] level;
    logic irq;
  } ctl_s;

  typedef struct packed {
    logic prev;
    logic flag;
  } edge_s;

endpackage : uart_irq_pkg

// ---- hw/rise_flag.sv ----
// sticky flag set by a rising level, cleared by a strobe
`timescale 1ns/100ps
`default_nettype none

module rise_flag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  input wire logic arm,
  input wire logic clear,
  output logic flag
);
  import uart_irq_pkg::*;

  edge_s st_r;
  edge_s st_nxt;

  // prev resets high so a level already high at reset is no event
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = level;
    // set beats a clear in the same cycle
    st_nxt.flag = (arm && level && !st_r.prev) || (st_r.flag && !clear);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '{prev: 1'b1, flag: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  chk_set_wins: assert property (@(posedge clk) disable iff (!resetn)
    arm && level && !st_r.prev |=> flag)
    else $error("rise flag lost a set");

endmodule : rise_flag

`default_nettype wire

// ---- hw/uart_interrupt_enable_logic.sv ----
// interrupt mask, source qualification and line status of the uart
//
// Operation
// - mask gates rx, tx, line, modem sources
// - mask bit 7: cts rising edge interrupt
// - mask bit 6: rts rising edge interrupt
// - mask bit 5: received xoff interrupt
// - mask bit 4 is sleep enable only
// - mask bit 3: any modem change interrupts
// - mask bit 2: any receive error interrupts
// - mask bit 1: tx empty interrupt
// - tx ready level 3, rx level 2
// - non-fifo rx interrupt follows holding data
// - fifo rx interrupt at trigger level
// - receive status follows trigger level too
// - line status 0: receive data present
// - tx drain interrupt, cleared by read/write
// - fifo polled mode gives no interrupts
// - line status 5/6: tx empties
// - line status 4:1: errors and break
// - line status 7: any fifo error
// - mask resets to all zero
// - upper mask bits need enhanced enable
// - fifo control bit 0 selects fifo mode
`include "uart_irq_map.svh"
`timescale 1ns/100ps
`default_nettype none

module uart_interrupt_enable_logic (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic isr_rd,
  input wire logic thr_wr,
  input wire logic efr_enh,
  input wire logic fifo_en,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic xoff_rcvd,
  input wire logic [3:0] msr_delta,
  input wire logic [3:0] lsr_err,
  input wire logic fifo_data_err,
  input wire logic rx_holding_full,
  input wire logic [7:0] rx_fill,
  input wire logic [7:0] rx_trig,
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  output logic irq,
  output logic [7:0] mask_rdata,
  output logic sleep_en,
  output logic [7:0] line_status,
  output logic rx_trig_status,
  output logic rx_ready_irq,
  output logic tx_ready_irq,
  output logic [2:0] irq_level
);
  import uart_irq_pkg::*;

  // ****************************************************************
  // edge sources
  // ****************************************************************

  ctl_s st_r;
  ctl_s st_nxt;
  logic cts_flag;
  logic rts_flag;
  logic xoff_flag;
  logic tx_drained;
  logic hi_clear;
  logic tx_clear;

  assign hi_clear = isr_rd;
  assign tx_clear = isr_rd || thr_wr;

  rise_flag u_cts (
    .clk(clk),
    .resetn(resetn),
    .level(cts_n),
    .arm(st_r.mask[`MASK_CTS]),
    .clear(hi_clear),
    .flag(cts_flag)
  );

  rise_flag u_rts (
    .clk(clk),
    .resetn(resetn),
    .level(rts_n),
    .arm(st_r.mask[`MASK_RTS]),
    .clear(hi_clear),
    .flag(rts_flag)
  );

  rise_flag u_xoff (
    .clk(clk),
    .resetn(resetn),
    .level(xoff_rcvd),
    .arm(st_r.mask[`MASK_XOFF]),
    .clear(hi_clear),
    .flag(xoff_flag)
  );

  // only the moment the fifo runs dry counts, not a standing empty
  rise_flag u_tx_drain (
    .clk(clk),
    .resetn(resetn),
    .level(tx_fifo_empty),
    .arm(fifo_en && st_r.mask[`MASK_TX]),
    .clear(tx_clear),
    .flag(tx_drained)
  );

  // ****************************************************************
  // mask register and qualification
  // ****************************************************************

  always_comb begin
    mode_e mode;
    logic polled;
    logic rx_hit;
    logic tx_hit;
    logic ls_hit;
    logic ms_hit;
    logic hi_hit;
    mode = MODE_PLAIN;
    polled = 1'b0;
    rx_hit = 1'b0;
    tx_hit = 1'b0;
    ls_hit = 1'b0;
    ms_hit = 1'b0;
    hi_hit = 1'b0;
    st_nxt = st_r;
    if (mask_wr) begin
      st_nxt.mask[3:0] = mask_wdata[3:0];
      if (efr_enh) begin
        st_nxt.mask[7:4] = mask_wdata[7:4];
      end
    end
    // upper half reads as zero while locked
    st_nxt.rdata = st_nxt.mask & (`MASK_LO_KEEP | {{4{efr_enh}}, 4'h0});
    polled = fifo_en && (st_r.mask[3:0] == 4'h0);
    if (!fifo_en) begin
      mode = MODE_PLAIN;
    end else if (polled) begin
      mode = MODE_FIFO_POLL;
    end else begin
      mode = MODE_FIFO_INT;
    end
    unique case (mode)
      MODE_PLAIN: begin
        rx_hit = rx_holding_full;
        tx_hit = tx_fifo_empty;
      end
      MODE_FIFO_INT: begin
        rx_hit = rx_fill >= rx_trig;
        tx_hit = tx_drained;
      end
      MODE_FIFO_POLL: begin
        rx_hit = 1'b0;
        tx_hit = 1'b0;
      end
      default: begin
        rx_hit = 1'b0;
        tx_hit = 1'b0;
      end
    endcase
    st_nxt.rx_rdy = st_r.mask[`MASK_RX] && rx_hit;
    st_nxt.tx_rdy = st_r.mask[`MASK_TX] && tx_hit;
    st_nxt.rx_stat = fifo_en && st_nxt.rx_rdy;
    ls_hit = st_r.mask[`MASK_LS] && (lsr_err != 4'h0);
    ms_hit = st_r.mask[`MASK_MS] && (msr_delta != 4'h0);
    hi_hit = (st_r.mask[`MASK_CTS] && cts_flag) ||
             (st_r.mask[`MASK_RTS] && rts_flag) ||
             (st_r.mask[`MASK_XOFF] && xoff_flag);
    // sleep bit is never a source
    st_nxt.irq = !polled && (st_nxt.rx_rdy || st_nxt.tx_rdy ||
                 ls_hit || ms_hit || hi_hit);
    if (st_nxt.rx_rdy) begin
      st_nxt.level = `LVL_RX;
    end else if (st_nxt.tx_rdy) begin
      st_nxt.level = `LVL_TX;
    end else begin
      st_nxt.level = `LVL_NONE;
    end
    // ****************************************************************
    // line status
    // ****************************************************************
    st_nxt.line_status_reg[`LSR_DATA] = fifo_en ? (rx_fill != 8'h00)
                                    : rx_holding_full;
    st_nxt.line_status_reg[`LSR_ERR_MSB:`LSR_ERR_LSB] = lsr_err;
    st_nxt.line_status_reg[`LSR_TX_EMPTY] = tx_fifo_empty;
    st_nxt.line_status_reg[`LSR_ALL_EMPTY] = tx_fifo_empty && tx_shift_empty;
    st_nxt.line_status_reg[`LSR_FIFO_ERR] = fifo_en && fifo_data_err;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '{mask: `MASK_RESET, rdata: `MASK_RESET,
                line_status_reg: `LSR_RESET, rx_rdy: 1'b0, tx_rdy: 1'b0,
                rx_stat: 1'b0, level: `LVL_NONE, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign irq = st_r.irq;
  assign mask_rdata = st_r.rdata;
  assign sleep_en = st_r.mask[`MASK_SLEEP];
  assign line_status = st_r.line_status_reg;
  assign rx_trig_status = st_r.rx_stat;
  assign rx_ready_irq = st_r.rx_rdy;
  assign tx_ready_irq = st_r.tx_rdy;
  assign irq_level = st_r.level;

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_mask_reset: assert property (disable iff (1'b0)
    !resetn |=> st_r.mask == 8'h00 && !irq && !sleep_en)
    else $error("mask not cleared by reset");

  chk_upper_lock: assert property (
    mask_wr && !efr_enh |=> st_r.mask[7:4] == $past(st_r.mask[7:4]))
    else $error("upper mask written while locked");

  chk_sleep_bit: assert property (
    mask_wr && efr_enh |=> sleep_en == $past(mask_wdata[4]))
    else $error("sleep enable not taken from mask write");

  chk_rx_plain: assert property (
    !fifo_en && st_r.mask[0] && rx_holding_full |=> rx_ready_irq && irq)
    else $error("non-fifo rx interrupt missing");

  chk_rx_trig: assert property (
    fifo_en && st_r.mask[0] && rx_fill >= rx_trig
      |=> rx_ready_irq && rx_trig_status && irq_level == 3'h2)
    else $error("rx trigger interrupt missing");

  chk_rx_below: assert property (
    fifo_en && rx_fill < rx_trig |=> !rx_ready_irq && !rx_trig_status)
    else $error("rx interrupt held below trigger");

  chk_tx_drain: assert property (
    $rose(tx_fifo_empty) && fifo_en && st_r.mask[1]
      ##1 fifo_en && st_r.mask[1] |=> tx_ready_irq)
    else $error("tx drain interrupt missing");

  chk_tx_clear: assert property (
    fifo_en && isr_rd && tx_fifo_empty && $past(tx_fifo_empty)
      ##1 fifo_en && tx_fifo_empty |=> !tx_ready_irq)
    else $error("tx interrupt not cleared by read");

  chk_cts_edge: assert property (
    !fifo_en && st_r.mask[7] && $rose(cts_n)
      ##1 !fifo_en && st_r.mask[7] |=> irq)
    else $error("cts rising edge gave no interrupt");

  chk_rts_edge: assert property (
    !fifo_en && st_r.mask[6] && $rose(rts_n)
      ##1 !fifo_en && st_r.mask[6] |=> irq)
    else $error("rts rising edge gave no interrupt");

  chk_xoff_edge: assert property (
    !fifo_en && st_r.mask[5] && $rose(xoff_rcvd)
      ##1 !fifo_en && st_r.mask[5] |=> irq)
    else $error("xoff reception gave no interrupt");

  chk_tx_plain: assert property (
    !fifo_en && st_r.mask[1] && tx_fifo_empty |=> tx_ready_irq && irq)
    else $error("non-fifo tx interrupt missing");

  chk_modem_irq: assert property (
    st_r.mask[3] && msr_delta != 4'h0 |=> irq)
    else $error("modem change gave no interrupt");

  chk_line_irq: assert property (
    st_r.mask[2] && lsr_err != 4'h0 |=> irq)
    else $error("receive error gave no interrupt");

  chk_polled_quiet: assert property (
    fifo_en && st_r.mask[3:0] == 4'h0 |=> !irq)
    else $error("interrupt in fifo polled mode");

  chk_no_mask: assert property (
    st_r.mask == 8'h00 |=> !irq)
    else $error("interrupt with every source masked");

  chk_lsr_tx: assert property (
    1'b1 |=> line_status[5] == $past(tx_fifo_empty) &&
      line_status[6] == ($past(tx_fifo_empty) && $past(tx_shift_empty)))
    else $error("transmit empty status wrong");

  chk_lsr_data: assert property (
    fifo_en && rx_fill != 8'h00 |=> line_status[0])
    else $error("receive data status missing");

  chk_lsr_err: assert property (
    1'b1 |=> line_status[4:1] == $past(lsr_err) &&
      line_status[7] == ($past(fifo_en) && $past(fifo_data_err)))
    else $error("receive error status wrong");

  chk_tx_level: assert property (
    tx_ready_irq && !rx_ready_irq |-> irq_level == 3'h3)
    else $error("tx ready reported at wrong level");

  cov_rx_trig: cover property (fifo_en && rx_ready_irq && irq);
  cov_tx_drain: cover property (fifo_en && tx_ready_irq ##1 isr_rd);
  cov_cts_irq: cover property ($rose(cts_n) && st_r.mask[7] ##2 irq);
  cov_polled: cover property (fifo_en && st_r.mask[3:0] == 4'h0 &&
    line_status[0]);

endmodule : uart_interrupt_enable_logic

`default_nettype wire

// ---- tb/host_cpu.sv ----
// host cpu model driving the mask, source-read and holding-write strobes
`timescale 1ns/100ps
`default_nettype none

module host_cpu (
  input wire logic clk,
  output logic mask_wr,
  output logic [7:0] mask_wdata,
  output logic isr_rd,
  output logic thr_wr
);
  // ****************************************
  // one-cycle strobes, moved just after an edge
  // ****************************************
  initial begin
    mask_wr = 1'b0;
    mask_wdata = 8'h00;
    isr_rd = 1'b0;
    thr_wr = 1'b0;
  end

  task automatic write_mask(input logic [7:0] v);
    @(posedge clk);
    #1;
    mask_wr = 1'b1;
    mask_wdata = v;
    @(posedge clk);
    #1;
    mask_wr = 1'b0;
    // released bus: never leave the last value lying around
    mask_wdata = ~v;
  endtask : write_mask

  // acknowledges edge sources; status itself is polled each cycle
  task automatic read_isr();
    @(posedge clk);
    #1;
    isr_rd = 1'b1;
    @(posedge clk);
    #1;
    isr_rd = 1'b0;
  endtask : read_isr

  task automatic write_thr();
    @(posedge clk);
    #1;
    thr_wr = 1'b1;
    @(posedge clk);
    #1;
    thr_wr = 1'b0;
  endtask : write_thr
endmodule : host_cpu

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the uart interrupt enable logic
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic efr_enh = 1'b0;
  logic fifo_en = 1'b0;
  logic cts_n = 1'b1;
  logic rts_n = 1'b1;
  logic xoff_rcvd = 1'b0;
  logic [3:0] msr_delta = 4'h0;
  logic [3:0] lsr_err = 4'h0;
  logic fifo_data_err = 1'b0;
  logic rx_holding_full = 1'b0;
  logic [7:0] rx_fill = 8'h00;
  logic [7:0] rx_trig = 8'h01;
  logic tx_fifo_empty = 1'b1;
  logic tx_shift_empty = 1'b1;
  logic mask_wr, isr_rd, thr_wr, irq, sleep_en, rx_trig_status;
  logic rx_ready_irq, tx_ready_irq;
  logic [7:0] mask_wdata, mask_rdata, line_status;
  logic [2:0] irq_level;
  integer seed = 88881;
  int num_errors = 0;
  int n_compared = 0;
  logic run = 1'b0;
  logic [31:0] rnd;
  logic [7:0] masks [12] = '{8'h00, 8'hFF, 8'h01, 8'h02, 8'h04, 8'h08,
    8'h10, 8'h20, 8'h40, 8'h80, 8'hEF, 8'hE0};
  logic [7:0] m, e_rd, e_ls;
  logic [2:0] e_lv;
  logic [3:0] fl, pv, cur, arm, clr;
  logic e_irq, e_sl, e_rs, e_rx, e_tx, poll, rxq, txq;

  always #2.5 clk = ~clk;

  uart_interrupt_enable_logic i_dut (.clk, .resetn, .mask_wr, .mask_wdata,
    .isr_rd, .thr_wr, .efr_enh, .fifo_en, .cts_n, .rts_n, .xoff_rcvd,
    .msr_delta, .lsr_err, .fifo_data_err, .rx_holding_full, .rx_fill,
    .rx_trig, .tx_fifo_empty, .tx_shift_empty, .irq, .mask_rdata,
    .sleep_en, .line_status, .rx_trig_status, .rx_ready_irq,
    .tx_ready_irq, .irq_level);

  host_cpu i_host (.clk, .mask_wr, .mask_wdata, .isr_rd, .thr_wr);

  // ****************************************
  // reference model, one step per edge
  // ****************************************
  always @(posedge clk) begin
    if (!resetn) begin
      m = 8'h00;
      fl = 4'h0;
      pv = 4'hF;
      {e_rd, e_sl, e_irq, e_rs, e_rx, e_tx, e_lv} = '0;
      e_ls = 8'h60;
    end else begin
      poll = fifo_en && m[3:0] == 4'h0;
      rxq = m[0] && (fifo_en ? rx_fill >= rx_trig : rx_holding_full);
      txq = m[1] && (fifo_en ? fl[3] : tx_fifo_empty);
      e_irq = !poll && (rxq || txq || |(fl[2:0] & {m[5], m[6], m[7]})
        || m[2] && |lsr_err || m[3] && |msr_delta);
      e_rx = rxq;
      e_tx = txq;
      e_rs = fifo_en && rxq;
      e_lv = rxq ? 3'h2 : txq ? 3'h3 : 3'h0;
      e_ls = {fifo_en & fifo_data_err, tx_fifo_empty & tx_shift_empty,
        tx_fifo_empty, lsr_err, fifo_en ? rx_fill != 0 : rx_holding_full};
      cur = {tx_fifo_empty, xoff_rcvd, rts_n, cts_n};
      arm = {fifo_en & m[1], m[5], m[6], m[7]};
      clr = {isr_rd | thr_wr, {3{isr_rd}}};
      // set wins over a clear in the same cycle
      fl = (arm & cur & ~pv) | (fl & ~clr);
      pv = cur;
      if (mask_wr) begin
        m = {efr_enh ? mask_wdata[7:4] : m[7:4], mask_wdata[3:0]};
      end
      e_rd = {efr_enh ? m[7:4] : 4'h0, m[3:0]};
      e_sl = m[4];
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  always @(negedge clk) begin
    if (run) begin
      chk("irq", e_irq, irq);
      chk("mask_rdata", e_rd, mask_rdata);
      chk("sleep_en", e_sl, sleep_en);
      chk("line_status", e_ls, line_status);
      chk("rx_trig_status", e_rs, rx_trig_status);
      chk("rx_ready_irq", e_rx, rx_ready_irq);
      chk("tx_ready_irq", e_tx, tx_ready_irq);
      chk("irq_level", e_lv, irq_level);
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ****************************************
  // stimulus: each of the 12 listed mask patterns, fifo off and on
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    run = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    foreach (masks[i]) begin
      for (int f = 0; f < 2; f++) begin
        // inputs frozen here, so the read leaves no stale flag behind
        i_host.read_isr();
        fifo_en = f[0];
        efr_enh = i != 1;
        i_host.write_mask(masks[i]);
        repeat (60) begin
          @(posedge clk);
          #1;
          rnd = $random(seed);
          {cts_n, rts_n, xoff_rcvd, msr_delta, lsr_err, fifo_data_err,
            rx_holding_full, tx_fifo_empty, tx_shift_empty} = rnd[14:0];
          rx_fill = {1'b0, rnd[22:16]};
          rx_trig = rnd[31] ? rx_fill : {1'b0, rnd[29:23]};
          if (rnd[30:28] == 3'h0) i_host.read_isr();
          if (rnd[30:28] == 3'h1) i_host.write_thr();
        end
        $display("test mask %h fifo %0d done", masks[i], f);
      end
    end
    results();
  end

  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule : testbench

`default_nettype wire
